// File: common/ppk_pkg.sv
// Package: register map, field positions and reset values of the pad keeper block
package ppk_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 16;
   localparam int          CTRL_W          = 8;
   localparam logic [15:0] PAD_KEEPER_CTRL = 16'h8800;
   localparam logic [15:0] RESERVED_RD     = 16'h0000;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_ADDR_HOLD  = 0;
   localparam int BIT_DATA_HOLD  = 1;
   localparam int BIT_EMIF_CTRL  = 2;
   localparam int BIT_HOST_DATA  = 3;
   localparam int BIT_HOST_CTRL  = 4;
   localparam int BIT_WDOG_OUT   = 5;
   localparam int BIT_TEST_PINS  = 6;
   localparam int BIT_DEBUG_PINS = 7;
   // ---------------------------------------------------------------
   // Pin group widths
   // ---------------------------------------------------------------
   localparam int HOST_DATA_W = 8;
   localparam int EXT_DATA_W  = 32;
   localparam int EXT_ADDR_W  = 20;
   localparam int EMIF_CTRL_W = 16;
   localparam int HOST_CTRL_W = 11;
endpackage : ppk_pkg

// File: common/ppk_reg_if.sv
// Interface: control bits from the register file to the pad enable logic
interface ppk_reg_if;
   logic [ppk_pkg::CTRL_W-1:0] ctrl;
   modport regs (output ctrl);
   modport pads (input  ctrl);
endinterface : ppk_reg_if

// File: rtl/ppk_pad_enables.sv
// Module: turns disable bits into per-pin keeper and pull enables
module ppk_pad_enables (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // Control bits
   ppk_reg_if.pads                           cfg,
   // Pad enables, high enables the keeper or pull
   output logic                              debug_line1_pu_en,
   output logic                              debug_line0_pu_en,
   output logic [3:0]                        test_pull_en,
   output logic                              wdog_out_pu_en,
   output logic                              host_ctrl_line0_pu_en,
   output logic                              host_ctrl_line1_pd_en,
   output logic [ppk_pkg::HOST_CTRL_W-1:0]   host_ctrl_other_pu_en,
   output logic [ppk_pkg::HOST_DATA_W-1:0]   host_data_hold_en,
   output logic [ppk_pkg::EMIF_CTRL_W-1:0]   emif_ctrl_keep_en,
   output logic [ppk_pkg::EXT_DATA_W-1:0]    ext_data_hold_en,
   output logic [ppk_pkg::EXT_ADDR_W-1:0]    ext_addr_hold_en
);
   // ---------------------------------------------------------------
   // Enable decode
   // ---------------------------------------------------------------
   // Enables depend on the bit only; pin function is never looked at
   wire en_dbg  = ~cfg.ctrl[ppk_pkg::BIT_DEBUG_PINS];
   wire en_tst  = ~cfg.ctrl[ppk_pkg::BIT_TEST_PINS];
   wire en_wdg  = ~cfg.ctrl[ppk_pkg::BIT_WDOG_OUT];
   wire en_hc   = ~cfg.ctrl[ppk_pkg::BIT_HOST_CTRL];
   wire en_hd   = ~cfg.ctrl[ppk_pkg::BIT_HOST_DATA];
   wire en_pc   = ~cfg.ctrl[ppk_pkg::BIT_EMIF_CTRL];
   wire en_pd   = ~cfg.ctrl[ppk_pkg::BIT_DATA_HOLD];
   wire en_pa   = ~cfg.ctrl[ppk_pkg::BIT_ADDR_HOLD];

   // Registered so every top output comes straight from a flop;
   // reset value matches the all-enabled state of a cleared register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_line1_pu_en     <= 1'b1;
         debug_line0_pu_en     <= 1'b1;
         test_pull_en          <= '1;
         wdog_out_pu_en        <= 1'b1;
         host_ctrl_line0_pu_en <= 1'b1;
         host_ctrl_line1_pd_en <= 1'b1;
         host_ctrl_other_pu_en <= '1;
         host_data_hold_en     <= '1;
         emif_ctrl_keep_en     <= '1;
         ext_data_hold_en      <= '1;
         ext_addr_hold_en      <= '1;
      end else begin
         debug_line1_pu_en     <= en_dbg;
         debug_line0_pu_en     <= en_dbg;
         test_pull_en          <= {4{en_tst}};
         wdog_out_pu_en        <= en_wdg;
         host_ctrl_line0_pu_en <= en_hc;
         host_ctrl_line1_pd_en <= en_hc;
         host_ctrl_other_pu_en <= {ppk_pkg::HOST_CTRL_W{en_hc}};
         host_data_hold_en     <= {ppk_pkg::HOST_DATA_W{en_hd}};
         emif_ctrl_keep_en     <= {ppk_pkg::EMIF_CTRL_W{en_pc}};
         ext_data_hold_en      <= {ppk_pkg::EXT_DATA_W{en_pd}};
         ext_addr_hold_en      <= {ppk_pkg::EXT_ADDR_W{en_pa}};
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_DEBUG_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
      debug_line0_pu_en == debug_line1_pu_en)
      else $error("debug pullups disagree");
   AST_HOST_PAIR: assert property (@(posedge clk) disable iff (!rst_n)
      host_ctrl_line0_pu_en == host_ctrl_line1_pd_en)
      else $error("host control pulls disagree");
endmodule : ppk_pad_enables

// File: rtl/ppk_top.sv
// Module: pad keeper control register with its read and write port
// ---------------------------------------------------------------
// Summary of operation
// - One 16-bit register at 0x8800, low eight bits read/write, reset zero
// - Bit 7 set turns off pullups on both debug lines
// - Bit 6 set turns off test-access pullups and pulldown
// - Bit 5 set turns off the watchdog output pullup
// - Bit 4 set turns off host control line0 pullup, line1 pulldown
// - Bit 3 set turns off holders on eight host data lines
// - Bit 2 set turns off memory interface control holders and pullups
// - Bit 1 set turns off holders on 32 external data lines
// - Bit 0 set turns off holders on external address bits 21..2
// - Enables follow their bit alone, whatever the pin's function
module ppk_top (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // Register port
   input  wire logic [ppk_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [ppk_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [ppk_pkg::DATA_W-1:0]  reg_rdata,
   // Pad enables, high enables the keeper or pull
   output logic                             debug_line1_pu_en,
   output logic                             debug_line0_pu_en,
   output logic      [3:0]                  test_pull_en,
   output logic                             wdog_out_pu_en,
   output logic                             host_ctrl_line0_pu_en,
   output logic                             host_ctrl_line1_pd_en,
   output logic [ppk_pkg::HOST_CTRL_W-1:0]  host_ctrl_other_pu_en,
   output logic [ppk_pkg::HOST_DATA_W-1:0]  host_data_hold_en,
   output logic [ppk_pkg::EMIF_CTRL_W-1:0]  emif_ctrl_keep_en,
   output logic [ppk_pkg::EXT_DATA_W-1:0]   ext_data_hold_en,
   output logic [ppk_pkg::EXT_ADDR_W-1:0]   ext_addr_hold_en
);
   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   logic [ppk_pkg::CTRL_W-1:0] ctrl_q;
   logic [ppk_pkg::CTRL_W-1:0] ctrl_d;
   logic [ppk_pkg::DATA_W-1:0] rdata_d;
   ppk_reg_if                  cfg_if ();

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Zero-extends the stored byte to bus width; reserved bits stay low
   // so software never sees stale write data in the upper byte
   function automatic logic [ppk_pkg::DATA_W-1:0] widen(
      input logic [ppk_pkg::CTRL_W-1:0] v
   );
      return ppk_pkg::DATA_W'(v);
   endfunction : widen

   // Write data bits, one per pin group
   wire w_dbg = reg_wdata[ppk_pkg::BIT_DEBUG_PINS];
   wire w_tst = reg_wdata[ppk_pkg::BIT_TEST_PINS];
   wire w_wdg = reg_wdata[ppk_pkg::BIT_WDOG_OUT];
   wire w_hc  = reg_wdata[ppk_pkg::BIT_HOST_CTRL];
   wire w_hd  = reg_wdata[ppk_pkg::BIT_HOST_DATA];
   wire w_pc  = reg_wdata[ppk_pkg::BIT_EMIF_CTRL];
   wire w_pd  = reg_wdata[ppk_pkg::BIT_DATA_HOLD];
   wire w_pa  = reg_wdata[ppk_pkg::BIT_ADDR_HOLD];
   // Stored bits, one per pin group
   wire c_dbg = ctrl_q[ppk_pkg::BIT_DEBUG_PINS];
   wire c_tst = ctrl_q[ppk_pkg::BIT_TEST_PINS];
   wire c_wdg = ctrl_q[ppk_pkg::BIT_WDOG_OUT];
   wire c_hc  = ctrl_q[ppk_pkg::BIT_HOST_CTRL];
   wire c_hd  = ctrl_q[ppk_pkg::BIT_HOST_DATA];
   wire c_pc  = ctrl_q[ppk_pkg::BIT_EMIF_CTRL];
   wire c_pd  = ctrl_q[ppk_pkg::BIT_DATA_HOLD];
   wire c_pa  = ctrl_q[ppk_pkg::BIT_ADDR_HOLD];

   wire hit    = (reg_addr == ppk_pkg::PAD_KEEPER_CTRL);
   wire wr_hit = reg_wr & hit;
   wire rd_hit = reg_rd & hit;

   // Only the low byte is stored; upper write bits are dropped
   assign ctrl_d = wr_hit ? reg_wdata[ppk_pkg::CTRL_W-1:0] : ctrl_q;
   // Unmapped reads and idle cycles return zero
   assign rdata_d = rd_hit ? widen(ctrl_q) : ppk_pkg::RESERVED_RD;
   assign cfg_if.ctrl = ctrl_q;

   // Control register, all pulls and keepers enabled out of reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= ppk_pkg::CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= ppk_pkg::RESERVED_RD;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Pad enable stage
   // ---------------------------------------------------------------
   ppk_pad_enables u_pads (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .cfg                   (cfg_if.pads),
      .debug_line1_pu_en     (debug_line1_pu_en),
      .debug_line0_pu_en     (debug_line0_pu_en),
      .test_pull_en          (test_pull_en),
      .wdog_out_pu_en        (wdog_out_pu_en),
      .host_ctrl_line0_pu_en (host_ctrl_line0_pu_en),
      .host_ctrl_line1_pd_en (host_ctrl_line1_pd_en),
      .host_ctrl_other_pu_en (host_ctrl_other_pu_en),
      .host_data_hold_en     (host_data_hold_en),
      .emif_ctrl_keep_en     (emif_ctrl_keep_en),
      .ext_data_hold_en      (ext_data_hold_en),
      .ext_addr_hold_en      (ext_addr_hold_en)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_WRITE_STORES: assert property (@(posedge clk) disable iff (!rst_n)
      wr_hit |=> ctrl_q == $past(reg_wdata[7:0]))
      else $error("write not stored");
   AST_READ_BACK: assert property (@(posedge clk) disable iff (!rst_n)
      rd_hit |=> reg_rdata == widen($past(ctrl_q)))
      else $error("read data wrong");
   AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rdata[15:8] == 8'h00)
      else $error("reserved bits not zero");
   AST_MISS_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      (reg_rd && !hit) |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   AST_NO_WRITE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> $stable(ctrl_q))
      else $error("register changed without write");
   AST_DEBUG_PU: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 debug_line0_pu_en == !$past(ctrl_q[7]))
      else $error("debug pullup mismatch");
   AST_TEST_PU: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 test_pull_en == {4{!$past(ctrl_q[6])}})
      else $error("test pull mismatch");
   AST_WDOG_PU: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 wdog_out_pu_en == !$past(ctrl_q[5]))
      else $error("watchdog pullup mismatch");
   AST_HOST_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 host_ctrl_line1_pd_en == !$past(ctrl_q[4]))
      else $error("host control pull mismatch");
   AST_HOST_DATA: assert property (@(posedge clk) disable iff (!rst_n)
      wr_hit |=> ##1 host_data_hold_en == {8{!$past(reg_wdata[3], 2)}})
      else $error("host data hold mismatch");
   AST_EMIF_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 emif_ctrl_keep_en == {16{!$past(ctrl_q[2])}})
      else $error("emif control keeper mismatch");
   AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 ext_data_hold_en == {32{!$past(ctrl_q[1])}})
      else $error("data hold mismatch");
   AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 ext_addr_hold_en == {20{!$past(ctrl_q[0])}})
      else $error("address hold mismatch");

   // ---------------------------------------------------------------
   // Checks: a set bit turns its group off two edges after the write
   // ---------------------------------------------------------------
   // Two edges: one to store the bit, one for the registered enable
   AST_D1_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_dbg) |=> ##1 !debug_line1_pu_en)
      else $error("debug line1 pullup not off");
   AST_D0_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_dbg) |=> ##1 !debug_line0_pu_en)
      else $error("debug line0 pullup not off");
   AST_TP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_tst) |=> ##1 test_pull_en == '0)
      else $error("test pulls not off");
   AST_WD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_wdg) |=> ##1 !wdog_out_pu_en)
      else $error("watchdog pullup not off");
   AST_H0_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hc) |=> ##1 !host_ctrl_line0_pu_en)
      else $error("host line0 pullup not off");
   AST_H1_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hc) |=> ##1 !host_ctrl_line1_pd_en)
      else $error("host line1 pulldown not off");
   AST_HO_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hc) |=> ##1 host_ctrl_other_pu_en == '0)
      else $error("host control pullups not off");
   AST_HD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hd) |=> ##1 host_data_hold_en == '0)
      else $error("host data holders not off");
   AST_PC_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_pc) |=> ##1 emif_ctrl_keep_en == '0)
      else $error("memory control keepers not off");
   AST_PD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_pd) |=> ##1 ext_data_hold_en == '0)
      else $error("data holders not off");
   AST_PA_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_pa) |=> ##1 ext_addr_hold_en == '0)
      else $error("address holders not off");

   // ---------------------------------------------------------------
   // Checks: a cleared bit turns its group back on
   // ---------------------------------------------------------------
   AST_D1_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_dbg) |=> ##1 debug_line1_pu_en)
      else $error("debug line1 pullup not on");
   AST_D0_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_dbg) |=> ##1 debug_line0_pu_en)
      else $error("debug line0 pullup not on");
   AST_TP_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_tst) |=> ##1 test_pull_en == '1)
      else $error("test pulls not on");
   AST_WD_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_wdg) |=> ##1 wdog_out_pu_en)
      else $error("watchdog pullup not on");
   AST_H0_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_hc) |=> ##1 host_ctrl_line0_pu_en)
      else $error("host line0 pullup not on");
   AST_H1_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_hc) |=> ##1 host_ctrl_line1_pd_en)
      else $error("host line1 pulldown not on");
   AST_HO_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_hc) |=> ##1 host_ctrl_other_pu_en == '1)
      else $error("host control pullups not on");
   AST_HD_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_hd) |=> ##1 host_data_hold_en == '1)
      else $error("host data holders not on");
   AST_PC_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_pc) |=> ##1 emif_ctrl_keep_en == '1)
      else $error("memory control keepers not on");
   AST_PD_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_pd) |=> ##1 ext_data_hold_en == '1)
      else $error("data holders not on");
   AST_PA_ON: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !w_pa) |=> ##1 ext_addr_hold_en == '1)
      else $error("address holders not on");

   // ---------------------------------------------------------------
   // Checks: no write means no enable moves
   // ---------------------------------------------------------------
   // Pads must not glitch on reads or on writes to other addresses
   AST_D1_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(debug_line1_pu_en))
      else $error("debug line1 pullup moved");
   AST_D0_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(debug_line0_pu_en))
      else $error("debug line0 pullup moved");
   AST_TP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(test_pull_en))
      else $error("test pulls moved");
   AST_WD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(wdog_out_pu_en))
      else $error("watchdog pullup moved");
   AST_H0_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(host_ctrl_line0_pu_en))
      else $error("host line0 pullup moved");
   AST_H1_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(host_ctrl_line1_pd_en))
      else $error("host line1 pulldown moved");
   AST_HO_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(host_ctrl_other_pu_en))
      else $error("host control pullups moved");
   AST_HD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(host_data_hold_en))
      else $error("host data holders moved");
   AST_PC_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(emif_ctrl_keep_en))
      else $error("memory control keepers moved");
   AST_PD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(ext_data_hold_en))
      else $error("data holders moved");
   AST_PA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_hit |=> ##1 $stable(ext_addr_hold_en))
      else $error("address holders moved");

   // ---------------------------------------------------------------
   // Checks: rewriting a bit with its own value leaves its group alone
   // ---------------------------------------------------------------
   // Groups are independent, so a write aimed at one never upsets another
   AST_D1_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_dbg == c_dbg) |=> ##1 $stable(debug_line1_pu_en))
      else $error("debug line1 pullup upset");
   AST_D0_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_dbg == c_dbg) |=> ##1 $stable(debug_line0_pu_en))
      else $error("debug line0 pullup upset");
   AST_TP_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_tst == c_tst) |=> ##1 $stable(test_pull_en))
      else $error("test pulls upset");
   AST_WD_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_wdg == c_wdg) |=> ##1 $stable(wdog_out_pu_en))
      else $error("watchdog pullup upset");
   AST_H0_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hc == c_hc) |=> ##1 $stable(host_ctrl_line0_pu_en))
      else $error("host line0 pullup upset");
   AST_H1_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hc == c_hc) |=> ##1 $stable(host_ctrl_line1_pd_en))
      else $error("host line1 pulldown upset");
   AST_HO_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hc == c_hc) |=> ##1 $stable(host_ctrl_other_pu_en))
      else $error("host control pullups upset");
   AST_HD_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_hd == c_hd) |=> ##1 $stable(host_data_hold_en))
      else $error("host data holders upset");
   AST_PC_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_pc == c_pc) |=> ##1 $stable(emif_ctrl_keep_en))
      else $error("memory control keepers upset");
   AST_PD_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_pd == c_pd) |=> ##1 $stable(ext_data_hold_en))
      else $error("data holders upset");
   AST_PA_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && w_pa == c_pa) |=> ##1 $stable(ext_addr_hold_en))
      else $error("address holders upset");
endmodule : ppk_top

// File: verif/ppk_pad_model.sv
// Partner model: levels of undriven pins as set by their pulls
module ppk_pad_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Pull enables from the block
   input  wire logic dbg_pu_en,
   input  wire logic trst_pd_en,
   // Resolved pin levels
   output logic      dbg_lvl,
   output logic      trst_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic float_q;
   // An unpulled pin has no level; wander so a stale value never passes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) float_q <= 1'b0;
      else float_q <= ~float_q;
   end
   // A pin with its pull on settles at the pull's level
   assign dbg_lvl  = dbg_pu_en ? 1'b1 : float_q;
   assign trst_lvl = trst_pd_en ? 1'b0 : float_q;
endmodule : ppk_pad_model

// File: verif/ppk_top_tb.sv
// Testbench: register port and pad enables of the pad keeper block
module ppk_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Signals and scoreboard
   // ---------------------------------------------------------------
   logic        clk, rst_n, reg_wr, reg_rd, rd_pend, d1, d0, wd, h0, h1;
   logic        lvl_dbg, lvl_trst;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, a, d, ec;
   logic [3:0]  tp;
   logic [10:0] ho;
   logic [7:0]  hd, exp_ctrl, e;
   logic [31:0] xd;
   logic [19:0] xa;
   logic [15:0] exp_q[$];
   int          mismatches, n_checks, seed;
   ppk_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .debug_line1_pu_en(d1), .debug_line0_pu_en(d0),
      .test_pull_en(tp), .wdog_out_pu_en(wd), .host_ctrl_line0_pu_en(h0),
      .host_ctrl_line1_pd_en(h1), .host_ctrl_other_pu_en(ho),
      .host_data_hold_en(hd), .emif_ctrl_keep_en(ec),
      .ext_data_hold_en(xd), .ext_addr_hold_en(xa));
   ppk_pad_model pads_far (.clk(clk), .rst_n(rst_n), .dbg_pu_en(d1),
      .trst_pd_en(tp[3]), .dbg_lvl(lvl_dbg), .trst_lvl(lvl_trst));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] expv);
      n_checks++;
      if (seen !== expv) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask : chk
   // Strobes are set by each task once, so back-to-back calls never clash
   task wr(input logic [15:0] adr, input logic [15:0] dat);
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b0;
      reg_addr  <= adr;
      reg_wdata <= dat;
      if (adr == 16'h8800) exp_ctrl = dat[7:0];
      @(posedge clk);
   endtask : wr
   task rd(input logic [15:0] adr);
      reg_rd   <= 1'b1;
      reg_wr   <= 1'b0;
      reg_addr <= adr;
      exp_q.push_back(adr == 16'h8800 ? {8'h00, exp_ctrl} : 16'h0000);
      @(posedge clk);
   endtask : rd
   task idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : idle
   // Needs one edge after the write's edge; the caller provides two
   task pads;
      #2;
      e = ~exp_ctrl;
      chk(d1, e[7]);
      chk(d0, e[7]);
      chk(tp, {4{e[6]}});
      chk(wd, e[5]);
      chk({h1, h0, ho}, {13{e[4]}});
      chk(hd, {8{e[3]}});
      chk(ec, {16{e[2]}});
      chk(xd, {32{e[1]}});
      chk(xa, {20{e[0]}});
      if (e[7]) chk(lvl_dbg, 1'b1);
      if (e[6]) chk(lvl_trst, 1'b0);
      @(posedge clk);
   endtask : pads
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // ---------------------------------------------------------------
   // Clock, read monitor and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) rd_pend <= 1'b0;
      else rd_pend <= reg_rd;
   end
   // Read data may only show in the cycle after a read strobe
   always @(negedge clk) begin
      if (rst_n && rd_pend) chk(reg_rdata, exp_q.pop_front());
      else if (rst_n) chk(reg_rdata, 16'h0000);
   end
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      $display("mismatch at %0t: run did not finish", $time);
      test_done;
   end
   // Main sequence: reset, walking bits, unmapped place, random, reset
   initial begin
      seed = 61;
      mismatches = 0;
      n_checks = 0;
      exp_ctrl = 8'h00;
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(16'h8800);
      idle;
      pads;
      for (int i = 0; i < 8; i++) begin
         d = 16'($random(seed));
         wr(16'h8800, {d[15:8], 8'h01 << i});
         rd(16'h8800);
         idle;
         pads;
      end
      wr(16'h8801, 16'h00FF);
      rd(16'h8801);
      rd(16'h8800);
      idle;
      pads;
      for (int i = 0; i < 24; i++) begin
         a = $random(seed) & 1 ? 16'h8800 : 16'($random(seed));
         d = 16'($random(seed));
         wr(a, d);
         rd(a);
         idle;
         pads;
      end
      wr(16'h8800, 16'h00AA);
      wr(16'h8800, 16'h0055);
      rd(16'h8800);
      idle;
      pads;
      rst_n <= 1'b0;
      exp_ctrl = 8'h00;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      pads;
      test_done;
   end
endmodule : ppk_top_tb
